/* File: hw/ppcb_bank.sv */
// file holds the port pin configuration bank top module
`timescale 1ns/10ps
//
// Contract
// (RULE1) mode 0eh config write loads pullup register; 1 disconnects pullup
// (RULE2) mode 0dh loads threshold register; 1 ttl, 0 cmos, when schmitt off
// (RULE3) mode 0ch port b or c loads schmitt register; 0 enables schmitt
// (RULE4) mode 0bh port b loads wake enable; 0 enables wakeup
// (RULE5) mode 0ah port b loads wake edge; 0 rising, 1 falling
// (RULE6) mode 09h/08h port b swaps working byte with pending/comparator
// (RULE7) pending bit sets on selected edge of enabled port b pin
// (RULE8) comparator bit 7 clear enables comparator
// (RULE9) comparator bit 6 clear drives result on port b pin 0
// (RULE10) comparator bit 0 reads 1 when pin 2 above pin 1
// (RULE11) reset loads ffh into all config registers except pending, comparator
// (RULE12) reset loads mode selector with 0fh
// (RULE13) port a, b, c data registers sit at 05h, 06h, 07h
// (RULE14) without port c, 07h is a plain ram byte
// (RULE15) mode 0fh loads direction; 1 input, 0 output
// (RULE16) software keeps mode within 08h to 0fh; value holds until rewritten
// (RULE17) data writes latch even for input pins
// (RULE18) data reads return pin levels, not latch
// (RULE19) unassigned port and mode pairs are ignored
// (RULE20) pending bit stays set until software overwrites by exchange
module ppcb_bank #(
   parameter int  PORT_A_WIDTH = 4,
   parameter bit  HAS_PORT_C   = 1'b1
) (
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       resetn_in,
   // mode selector access
   input  wire logic       mode_wr_in,
   input  wire logic [3:0] mode_data_in,
   output logic [3:0]      mode_out,
   // configuration write (port_config_write_instr)
   input  wire logic       cfg_wr_in,
   input  wire logic [1:0] cfg_port_in,
   input  wire logic [7:0] cfg_data_in,
   output logic            xchg_valid_out,
   output logic [7:0]      xchg_data_out,
   // file register access
   input  wire logic       file_wr_in,
   input  wire logic       file_rd_in,
   input  wire logic [4:0] file_addr_in,
   input  wire logic [7:0] file_wdata_in,
   output logic            file_hit_out,
   output logic [7:0]      file_rdata_out,
   // port pins
   input  wire logic [7:0] pin_a_in,
   input  wire logic [7:0] pin_b_in,
   input  wire logic [7:0] pin_c_in,
   output logic [7:0]      pin_a_out,
   output logic [7:0]      pin_b_out,
   output logic [7:0]      pin_c_out,
   output logic [7:0]      pin_a_oe_n_out,
   output logic [7:0]      pin_b_oe_n_out,
   output logic [7:0]      pin_c_oe_n_out,
   // analog front-end controls
   input  wire logic       cmp_plus_gt_minus_in,
   output logic [7:0]      pullup_off_a_out,
   output logic [7:0]      pullup_off_b_out,
   output logic [7:0]      pullup_off_c_out,
   output logic [7:0]      ttl_sel_a_out,
   output logic [7:0]      ttl_sel_b_out,
   output logic [7:0]      ttl_sel_c_out,
   output logic [7:0]      schmitt_off_b_out,
   output logic [7:0]      schmitt_off_c_out,
   output logic            cmp_enable_out,
   output logic [7:0]      wake_pending_out,
   output logic            wake_event_out
);
   // elaboration check: port a has one to eight pins, the mask logic serves no more
   if (PORT_A_WIDTH < 1 || PORT_A_WIDTH > 8) begin : g_bad_width
      $error("PORT_A_WIDTH must be 1 to 8");
   end

   localparam int NUM_PORTS = 3;
   localparam int NUM_KINDS = 3; // direction, pullup, threshold per port

   logic [3:0] mode_reg;
   logic [7:0] data_a_reg;
   logic [7:0] data_b_reg;
   logic [7:0] data_c_reg;
   logic [7:0] wake_pending_reg;
   logic [7:0] comparator_ctrl_reg;
   logic [7:0] pin_b_prev_reg;
   logic [7:0] xchg_data_reg;
   logic       xchg_valid_reg;
   logic [7:0] file_rdata_reg;
   logic [7:0] wake_enable_b;
   logic [7:0] wake_edge_b;
   logic [7:0] schmitt_ctrl_b;
   logic [7:0] schmitt_ctrl_c;
   logic [7:0] cfg_q [NUM_PORTS*NUM_KINDS];
   logic       cfg_we [NUM_PORTS*NUM_KINDS];
   logic       we_wken;
   logic       we_wked;
   logic       we_st_b;
   logic       we_st_c;
   logic       xchg_pnd;
   logic       xchg_cmp;
   logic [7:0] edge_seen;
   logic [7:0] pin_a_mask;
   logic [7:0] cmp_drive;

   // write decode; pairs with no register fall through and do nothing (see RULE19)
   assign xchg_pnd = cfg_wr_in && cfg_port_in == ppcb_pkg::PORT_B && mode_reg == ppcb_pkg::MODE_WKPND;
   assign xchg_cmp = cfg_wr_in && cfg_port_in == ppcb_pkg::PORT_B && mode_reg == ppcb_pkg::MODE_CMP;
   assign we_wken  = cfg_wr_in && cfg_port_in == ppcb_pkg::PORT_B && mode_reg == ppcb_pkg::MODE_WKEN;   // see RULE4
   assign we_wked  = cfg_wr_in && cfg_port_in == ppcb_pkg::PORT_B && mode_reg == ppcb_pkg::MODE_WKEDGE; // see RULE5
   assign we_st_b  = cfg_wr_in && cfg_port_in == ppcb_pkg::PORT_B && mode_reg == ppcb_pkg::MODE_SCHMITT; // see RULE3
   assign we_st_c  = cfg_wr_in && cfg_port_in == ppcb_pkg::PORT_C && mode_reg == ppcb_pkg::MODE_SCHMITT
                     && HAS_PORT_C;

   // per-port direction, pullup and threshold registers, all reset to ffh
   genvar gp;
   generate
      for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
         assign cfg_we[gp*NUM_KINDS+0] = cfg_wr_in && cfg_port_in == 2'(gp)
                                         && mode_reg == ppcb_pkg::MODE_DIR;     // see RULE15
         assign cfg_we[gp*NUM_KINDS+1] = cfg_wr_in && cfg_port_in == 2'(gp)
                                         && mode_reg == ppcb_pkg::MODE_PULLUP;  // see RULE1
         assign cfg_we[gp*NUM_KINDS+2] = cfg_wr_in && cfg_port_in == 2'(gp)
                                         && mode_reg == ppcb_pkg::MODE_LEVEL;   // see RULE2
         for (genvar gk = 0; gk < NUM_KINDS; gk++) begin : g_kind
            ppcb_cfg_reg #(
               .RESET_VALUE(ppcb_pkg::CFG_RESET)                                // see RULE11
            ) u_reg (
               .clk_in    (clk_in),
               .resetn_in (resetn_in),
               .wr_en_in  (cfg_we[gp*NUM_KINDS+gk]),
               .wr_data_in(cfg_data_in),
               .value_out (cfg_q[gp*NUM_KINDS+gk])
            );
         end
      end
   endgenerate

   // port b wake enable; resets to all disabled so no stray edge can set a pending bit
   ppcb_cfg_reg #(
      .RESET_VALUE(ppcb_pkg::CFG_RESET)                                // see RULE11
   ) u_wken (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .wr_en_in  (we_wken),
      .wr_data_in(cfg_data_in),
      .value_out (wake_enable_b)
   );

   // port b wake edge select
   ppcb_cfg_reg #(
      .RESET_VALUE(ppcb_pkg::CFG_RESET)                                // see RULE11
   ) u_wked (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .wr_en_in  (we_wked),
      .wr_data_in(cfg_data_in),
      .value_out (wake_edge_b)
   );

   // port b schmitt select
   ppcb_cfg_reg #(
      .RESET_VALUE(ppcb_pkg::CFG_RESET)                                // see RULE11
   ) u_st_b (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .wr_en_in  (we_st_b),
      .wr_data_in(cfg_data_in),
      .value_out (schmitt_ctrl_b)
   );

   // port c schmitt select; never written when port c is absent
   ppcb_cfg_reg #(
      .RESET_VALUE(ppcb_pkg::CFG_RESET)                                // see RULE11
   ) u_st_c (
      .clk_in    (clk_in),
      .resetn_in (resetn_in),
      .wr_en_in  (we_st_c),
      .wr_data_in(cfg_data_in),
      .value_out (schmitt_ctrl_c)
   );

   // mode selector; software keeps it in range, value persists until rewritten
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         mode_reg <= ppcb_pkg::MODE_RESET;                 // see RULE12
      end else if (mode_wr_in) begin
         mode_reg <= mode_data_in;                         // see RULE16
      end
   end
   assign mode_out = mode_reg;

   // output latches take every write, whatever the direction
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         data_a_reg <= ppcb_pkg::ZERO_BYTE;
         data_b_reg <= ppcb_pkg::ZERO_BYTE;
         data_c_reg <= ppcb_pkg::ZERO_BYTE;
      end else if (file_wr_in) begin
         if (file_addr_in == ppcb_pkg::ADDR_PORT_A) begin
            data_a_reg <= file_wdata_in;                   // see RULE13, see RULE17
         end
         if (file_addr_in == ppcb_pkg::ADDR_PORT_B) begin
            data_b_reg <= file_wdata_in;
         end
         if (file_addr_in == ppcb_pkg::ADDR_PORT_C) begin
            data_c_reg <= file_wdata_in;                   // ram byte when port c is absent, see RULE14
         end
      end
   end

   // reads return pins; without port c the byte at 07h reads as ram
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         file_rdata_reg <= ppcb_pkg::ZERO_BYTE;
      end else if (file_rd_in) begin
         unique case (file_addr_in)
            ppcb_pkg::ADDR_PORT_A: file_rdata_reg <= pin_a_in & pin_a_mask;  // see RULE18
            ppcb_pkg::ADDR_PORT_B: file_rdata_reg <= pin_b_in;               // see RULE18
            ppcb_pkg::ADDR_PORT_C: file_rdata_reg <= HAS_PORT_C ? pin_c_in : data_c_reg; // see RULE14
            default:               file_rdata_reg <= ppcb_pkg::ZERO_BYTE;
         endcase
      end
   end
   assign file_rdata_out = file_rdata_reg;
   assign file_hit_out   = file_addr_in == ppcb_pkg::ADDR_PORT_A || file_addr_in == ppcb_pkg::ADDR_PORT_B
                           || file_addr_in == ppcb_pkg::ADDR_PORT_C;

   // previous port b level, for edge detection
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pin_b_prev_reg <= ppcb_pkg::ZERO_BYTE;
      end else begin
         pin_b_prev_reg <= pin_b_in;
      end
   end

   // selected edge on enabled pins; a set wake_edge bit chooses falling for its own pin
   assign edge_seen = ~wake_enable_b & ((~wake_edge_b & pin_b_in & ~pin_b_prev_reg)
                                      | (wake_edge_b & ~pin_b_in & pin_b_prev_reg)); // see RULE5, see RULE7

   // pending bits: exchange writes them, an edge in the same cycle still wins
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wake_pending_reg <= ppcb_pkg::ZERO_BYTE;
      end else if (xchg_pnd) begin
         wake_pending_reg <= cfg_data_in | edge_seen;     // see RULE6, see RULE20
      end else begin
         wake_pending_reg <= wake_pending_reg | edge_seen; // see RULE7, see RULE20
      end
   end
   assign wake_pending_out = wake_pending_reg;
   assign wake_event_out   = |wake_pending_reg;

   // comparator control: bits 7 and 6 writable, bit 0 tracks the result
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         comparator_ctrl_reg <= ppcb_pkg::CFG_RESET;
      end else begin
         if (xchg_cmp) begin
            comparator_ctrl_reg[ppcb_pkg::CMP_DISABLE_BIT] <= cfg_data_in[ppcb_pkg::CMP_DISABLE_BIT];
            comparator_ctrl_reg[ppcb_pkg::CMP_NOOUT_BIT]   <= cfg_data_in[ppcb_pkg::CMP_NOOUT_BIT];
         end
         // result is only meaningful while enabled; disabled reads 0
         comparator_ctrl_reg[ppcb_pkg::CMP_RESULT_BIT] <= cmp_enable_out & cmp_plus_gt_minus_in; // see RULE10
      end
   end
   assign cmp_enable_out = ~comparator_ctrl_reg[ppcb_pkg::CMP_DISABLE_BIT]; // see RULE8

   // exchange returns the old register contents for one cycle
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         xchg_valid_reg <= 1'b0;
         xchg_data_reg  <= ppcb_pkg::ZERO_BYTE;
      end else begin
         xchg_valid_reg <= xchg_pnd | xchg_cmp;
         if (xchg_pnd) begin
            xchg_data_reg <= wake_pending_reg;             // see RULE6
         end else if (xchg_cmp) begin
            xchg_data_reg <= comparator_ctrl_reg;          // see RULE6
         end
      end
   end
   assign xchg_valid_out = xchg_valid_reg;
   assign xchg_data_out  = xchg_data_reg;

   // pin drivers; oe is low while the pin drives
   assign pin_a_mask = 8'((1 << PORT_A_WIDTH) - 1);
   assign cmp_drive  = {7'h00, cmp_enable_out & ~comparator_ctrl_reg[ppcb_pkg::CMP_NOOUT_BIT]}; // see RULE9
   assign pin_a_out      = data_a_reg & pin_a_mask;
   assign pin_a_oe_n_out = cfg_q[0] | ~pin_a_mask;                              // see RULE15
   assign pin_b_out      = cmp_drive[ppcb_pkg::CMP_OUT_PIN]
                           ? {data_b_reg[7:1], comparator_ctrl_reg[ppcb_pkg::CMP_RESULT_BIT]} : data_b_reg;
   assign pin_b_oe_n_out = cfg_q[NUM_KINDS] & ~cmp_drive;                        // see RULE9, see RULE15
   assign pin_c_out      = HAS_PORT_C ? data_c_reg : ppcb_pkg::ZERO_BYTE;
   assign pin_c_oe_n_out = HAS_PORT_C ? cfg_q[2*NUM_KINDS] : ppcb_pkg::CFG_RESET;

   // analog-side controls
   assign pullup_off_a_out  = cfg_q[1];
   assign pullup_off_b_out  = cfg_q[NUM_KINDS+1];
   assign pullup_off_c_out  = cfg_q[2*NUM_KINDS+1];
   assign ttl_sel_a_out     = cfg_q[2];
   assign ttl_sel_b_out     = cfg_q[NUM_KINDS+2];
   assign ttl_sel_c_out     = cfg_q[2*NUM_KINDS+2];
   assign schmitt_off_b_out = schmitt_ctrl_b;
   assign schmitt_off_c_out = schmitt_ctrl_c;
endmodule

/* File: hw/ppcb_cfg_reg.sv */
// file holds one byte-wide configuration register
`timescale 1ns/10ps
module ppcb_cfg_reg #(
   parameter logic [7:0] RESET_VALUE = 8'hff
) (
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       resetn_in,
   // write port
   input  wire logic       wr_en_in,
   input  wire logic [7:0] wr_data_in,
   // contents
   output logic [7:0]      value_out
);
   // hold value, load on write
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         value_out <= RESET_VALUE;
      end else if (wr_en_in) begin
         value_out <= wr_data_in;
      end
   end
endmodule

/* File: hw/ppcb_pkg.sv */
// package: port configuration bank constants
package ppcb_pkg;
   // mode selector values
   localparam logic [3:0] MODE_CMP     = 4'h8;
   localparam logic [3:0] MODE_WKPND   = 4'h9;
   localparam logic [3:0] MODE_WKEDGE  = 4'ha;
   localparam logic [3:0] MODE_WKEN    = 4'hb;
   localparam logic [3:0] MODE_SCHMITT = 4'hc;
   localparam logic [3:0] MODE_LEVEL   = 4'hd;
   localparam logic [3:0] MODE_PULLUP  = 4'he;
   localparam logic [3:0] MODE_DIR     = 4'hf;
   localparam logic [3:0] MODE_RESET   = 4'hf;
   // port selectors for a configuration write
   localparam logic [1:0] PORT_A = 2'h0;
   localparam logic [1:0] PORT_B = 2'h1;
   localparam logic [1:0] PORT_C = 2'h2;
   // data-memory addresses
   localparam logic [4:0] ADDR_PORT_A = 5'h05;
   localparam logic [4:0] ADDR_PORT_B = 5'h06;
   localparam logic [4:0] ADDR_PORT_C = 5'h07;
   // reset values
   localparam logic [7:0] CFG_RESET = 8'hff;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   // comparator field positions
   localparam int CMP_DISABLE_BIT = 7;
   localparam int CMP_NOOUT_BIT   = 6;
   localparam int CMP_RESULT_BIT  = 0;
   localparam int CMP_OUT_PIN     = 0;
   localparam int CMP_MINUS_PIN   = 1;
   localparam int CMP_PLUS_PIN    = 2;
endpackage

/* File: tb/ppcb_bank_props.sv */
// checker for the port configuration bank
`timescale 1ns/10ps
module ppcb_bank_props (
   // clock and reset
   input wire logic       clk_in,
   input wire logic       resetn_in,
   // cpu side
   input wire logic       mode_wr_in,
   input wire logic [3:0] mode_data_in,
   input wire logic [3:0] mode_out,
   input wire logic       cfg_wr_in,
   input wire logic [1:0] cfg_port_in,
   input wire logic [7:0] cfg_data_in,
   input wire logic       xchg_valid_out,
   input wire logic       file_rd_in,
   input wire logic [4:0] file_addr_in,
   input wire logic       file_hit_out,
   input wire logic [7:0] file_rdata_out,
   // pins and state
   input wire logic [7:0] pin_b_in,
   input wire logic [7:0] pullup_off_a_out,
   input wire logic [7:0] wake_pending_out,
   input wire logic       wake_event_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!resetn_in);
   // exchange writes are port b under selector 8 or 9; 9 is the pending one
   wire xw = cfg_wr_in && cfg_port_in == 2'h1 && mode_out[3:1] == 3'b100;
   wire pw = xw && mode_out[0];
   mode_load_a: assert property (mode_wr_in |=> mode_out == $past(mode_data_in))
      else $error("mode selector not loaded");
   mode_hold_a: assert property (!mode_wr_in |=> $stable(mode_out))
      else $error("mode selector changed without a write");
   pullup_load_a: assert property (cfg_wr_in && mode_out == 4'he && cfg_port_in == 2'h0 |=>
      pullup_off_a_out == $past(cfg_data_in)) else $error("pullup byte not loaded");
   xchg_pulse_a: assert property (xw |=> xchg_valid_out)
      else $error("exchange not answered");
   xchg_cause_a: assert property (xchg_valid_out |-> $past(xw))
      else $error("exchange answer without an exchange write");
   // set bits may only drop through a pending exchange
   pend_hold_a: assert property (!pw |=>
      (wake_pending_out & $past(wake_pending_out)) == $past(wake_pending_out)) else $error("pending bit lost");
   file_hit_a: assert property (file_hit_out == (file_addr_in >= 5'h05 && file_addr_in <= 5'h07))
      else $error("port address decode wrong");
   pin_read_a: assert property (file_rd_in && file_addr_in == 5'h06 |=> file_rdata_out == $past(pin_b_in))
      else $error("port b read is not the pin level");
   cover property (pw);
   cover property ($rose(wake_event_out));
   cover property (file_rd_in && file_addr_in == 5'h06);
endmodule
bind ppcb_bank ppcb_bank_props u_ppcb_bank_props (.clk_in, .resetn_in, .mode_wr_in, .mode_data_in, .mode_out,
   .cfg_wr_in, .cfg_port_in, .cfg_data_in, .xchg_valid_out, .file_rd_in, .file_addr_in, .file_hit_out,
   .file_rdata_out, .pin_b_in, .pullup_off_a_out, .wake_pending_out, .wake_event_out);

/* File: tb/ppcb_bank_tb.sv */
// self-checking bench for the port configuration bank
`timescale 1ns/10ps
module ppcb_bank_tb;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic cmp_plus_gt_minus_in = 1'b0;
   logic [7:0] pin_a_in = 8'h00, pin_b_in = 8'h00, pin_c_in = 8'h00;
   logic mode_wr_in, cfg_wr_in, file_wr_in, file_rd_in, xchg_valid_out, file_hit_out, cmp_enable_out, wake_event_out;
   logic [1:0] cfg_port_in;
   logic [3:0] mode_data_in, mode_out;
   logic [4:0] file_addr_in;
   logic [7:0] cfg_data_in, xchg_data_out, file_wdata_in, file_rdata_out, pin_b_out, pin_b_oe_n_out, wake_pending_out;
   logic [7:0] pullup_off_a_out, pullup_off_b_out, pullup_off_c_out, ttl_sel_a_out, ttl_sel_b_out, ttl_sel_c_out;
   logic [7:0] schmitt_off_b_out, schmitt_off_c_out, old, q, v, w;
   logic [7:0] pin_a_out, pin_c_out, pin_a_oe_n_out, pin_c_oe_n_out;
   logic [7:0] e [9];
   int bad_count = 0;
   int compares = 0;
   ppcb_bank u_ppcb_bank (.clk_in, .resetn_in, .mode_wr_in, .mode_data_in, .mode_out, .cfg_wr_in, .cfg_port_in,
      .cfg_data_in, .xchg_valid_out, .xchg_data_out, .file_wr_in, .file_rd_in, .file_addr_in, .file_wdata_in,
      .file_hit_out, .file_rdata_out, .pin_a_in, .pin_b_in, .pin_c_in, .pin_a_out, .pin_b_out, .pin_c_out,
      .pin_a_oe_n_out, .pin_b_oe_n_out, .pin_c_oe_n_out, .cmp_plus_gt_minus_in, .pullup_off_a_out,
      .pullup_off_b_out, .pullup_off_c_out, .ttl_sel_a_out, .ttl_sel_b_out, .ttl_sel_c_out, .schmitt_off_b_out,
      .schmitt_off_c_out, .cmp_enable_out, .wake_pending_out, .wake_event_out);
   ppcb_cpu_model u_ppcb_cpu_model (.clk_in, .xchg_valid_in(xchg_valid_out), .xchg_data_in(xchg_data_out),
      .rdata_in(file_rdata_out), .mode_wr_out(mode_wr_in), .mode_data_out(mode_data_in), .cfg_wr_out(cfg_wr_in),
      .cfg_port_out(cfg_port_in), .cfg_data_out(cfg_data_in), .file_wr_out(file_wr_in), .file_rd_out(file_rd_in),
      .addr_out(file_addr_in), .wdata_out(file_wdata_in));
   always #4 clk_in = ~clk_in;
   // expected read: pins for the three ports, port a only four wide, zero elsewhere
   function automatic logic [7:0] exp_read(input logic [4:0] a);
      return a == 5'h05 ? pin_a_in & 8'h0f : a == 5'h06 ? pin_b_in : a == 5'h07 ? pin_c_in : 8'h00;
   endfunction
   // bits that saw the watched edge between two pin samples
   function automatic logic [7:0] edges(input logic [7:0] a, input logic [7:0] b, input int fall);
      return fall != 0 ? a & ~b : ~a & b;
   endfunction
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("mismatches %0d comparisons %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // run is under two hundred cycles; this limit is far beyond it
   initial begin
      #40000;
      bad_count++;
      report_and_stop();
   end
   initial begin
      void'($urandom(32'h26f2316c));
      repeat (4) @(posedge clk_in);
      #1;
      resetn_in = 1'b1;
      chk({4'h0, mode_out}, 8'h0f);
      chk(pullup_off_b_out, 8'hff);
      chk(ttl_sel_c_out, 8'hff);
      chk(pin_b_oe_n_out, 8'hff);
      chk({7'h0, cmp_enable_out}, 8'h00);
      // schmitt, level and pullup selectors on all ports; port a has no schmitt byte
      foreach (e[i]) e[i] = 8'hff;
      for (int m = 4; m < 7; m++) begin
         for (int p = 0; p < 3; p++) begin
            v = 8'($urandom);
            u_ppcb_cpu_model.cfg(3'(m), 2'(p), v, old);
            if (m != 4 || p != 0) e[(m - 4) * 3 + p] = v;
         end
      end
      // a schmitt write to the unused fourth port selector must change nothing
      u_ppcb_cpu_model.cfg(3'h4, 2'h3, ~e[2], old);
      chk(schmitt_off_b_out, e[1]);
      chk(schmitt_off_c_out, e[2]);
      chk(ttl_sel_a_out, e[3]);
      chk(ttl_sel_b_out, e[4]);
      chk(ttl_sel_c_out, e[5]);
      chk(pullup_off_a_out, e[6]);
      chk(pullup_off_b_out, e[7]);
      chk(pullup_off_c_out, e[8]);
      // latch written while pins are inputs, then turn pin 0 and a random set of the others to outputs
      v = 8'($urandom);
      w = 8'($urandom) & 8'hfe;
      u_ppcb_cpu_model.file_acc(1'b1, 5'h06, v, q);
      u_ppcb_cpu_model.cfg(3'h7, 2'h1, w, old);
      chk(pin_b_oe_n_out, w);
      chk(pin_b_out, v);
      // port a is four pins wide; port c keeps its reset direction
      u_ppcb_cpu_model.file_acc(1'b1, 5'h05, v, q);
      u_ppcb_cpu_model.file_acc(1'b1, 5'h07, ~v, q);
      u_ppcb_cpu_model.cfg(3'h7, 2'h0, 8'h00, old);
      chk(pin_a_oe_n_out, 8'hf0);
      chk(pin_a_out, v & 8'h0f);
      chk(pin_c_out, ~v);
      chk(pin_c_oe_n_out, 8'hff);
      // reads return pin levels; 04h, 08h and 09h sit outside the ports
      for (int i = 4; i < 10; i++) begin
         pin_a_in = 8'($urandom);
         pin_b_in = 8'($urandom);
         pin_c_in = 8'($urandom);
         u_ppcb_cpu_model.file_acc(1'b0, 5'(i), 8'h00, q);
         chk(q, exp_read(5'(i)));
      end
      // wakeup on the low nibble only, rising then falling; opposite edges must not count
      for (int f = 0; f < 2; f++) begin
         pin_b_in = f != 0 ? 8'hff : 8'h00;
         u_ppcb_cpu_model.cfg(3'h3, 2'h1, 8'hf0, old);
         u_ppcb_cpu_model.cfg(3'h2, 2'h1, f != 0 ? 8'hff : 8'h00, old);
         u_ppcb_cpu_model.cfg(3'h1, 2'h1, 8'h00, old);
         v = 8'($urandom) | 8'h01;
         w = pin_b_in;
         pin_b_in = w ^ v;
         repeat (3) @(posedge clk_in);
         #1;
         chk({7'h0, wake_event_out}, 8'h01);
         pin_b_in = w;
         u_ppcb_cpu_model.cfg(3'h1, 2'h1, 8'h00, old);
         chk(old, edges(w, w ^ v, f) & 8'h0f);
         chk(wake_pending_out, 8'h00);
      end
      // comparator enabled and routed, plus input above minus
      cmp_plus_gt_minus_in = 1'b1;
      u_ppcb_cpu_model.cfg(3'h0, 2'h1, 8'h00, old);
      chk(old, 8'hfe);
      chk({7'h0, cmp_enable_out}, 8'h01);
      chk({7'h0, pin_b_oe_n_out[0]}, 8'h00);
      chk({7'h0, pin_b_out[0]}, 8'h01);
      // plus input no longer above minus: the result bit drops
      cmp_plus_gt_minus_in = 1'b0;
      repeat (2) @(posedge clk_in);
      #1;
      chk({7'h0, pin_b_out[0]}, 8'h00);
      u_ppcb_cpu_model.cfg(3'h0, 2'h1, 8'hc0, old);
      chk(old, 8'h3e);
      report_and_stop();
   end
endmodule

/* File: tb/ppcb_cpu_model.sv */
// cpu core model issuing selector, configuration and file accesses
`timescale 1ns/10ps
module ppcb_cpu_model (
   // clock and answers
   input  wire logic       clk_in,
   input  wire logic       xchg_valid_in,
   input  wire logic [7:0] xchg_data_in,
   input  wire logic [7:0] rdata_in,
   // requests
   output logic            mode_wr_out = 1'b0,
   output logic [3:0]      mode_data_out = 4'hf,
   output logic            cfg_wr_out = 1'b0,
   output logic [1:0]      cfg_port_out = 2'h0,
   output logic [7:0]      cfg_data_out = 8'h00,
   output logic            file_wr_out = 1'b0,
   output logic            file_rd_out = 1'b0,
   output logic [4:0]      addr_out = 5'h00,
   output logic [7:0]      wdata_out = 8'h00
);
   // selector then configuration write; top selector bit fixed so no reserved value can go out
   task automatic cfg(input logic [2:0] m, input logic [1:0] p, input logic [7:0] d, output logic [7:0] old);
      @(posedge clk_in);
      #1;
      mode_data_out = {1'b1, m};
      mode_wr_out = 1'b1;
      @(posedge clk_in);
      #1;
      mode_wr_out = 1'b0;
      mode_data_out = ~mode_data_out;
      cfg_port_out = p;
      cfg_data_out = d;
      cfg_wr_out = 1'b1;
      @(posedge clk_in);
      #1;
      cfg_wr_out = 1'b0;
      cfg_data_out = ~d;
      old = 8'hxx;
      // the exchange answer may land on either of the next two edges
      repeat (2) begin
         if (xchg_valid_in) old = xchg_data_in;
         @(posedge clk_in);
         #1;
      end
   endtask
   // one file register access; read data is taken after the accepting edge
   task automatic file_acc(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
      @(posedge clk_in);
      #1;
      addr_out = a;
      wdata_out = d;
      file_wr_out = wr;
      file_rd_out = !wr;
      @(posedge clk_in);
      #1;
      file_wr_out = 1'b0;
      file_rd_out = 1'b0;
      q = rdata_in;
      addr_out = ~a;
      wdata_out = ~d;
   endtask
endmodule
